// ==== common/jif_regs.vh ====
`ifndef JIF_REGS_VH
`define JIF_REGS_VH

// Instruction register codes (16-bit)
`define JIF_IR_W 16
`define JIF_IR_IDCODE 16'h0004
`define JIF_IR_BYPASS 16'hFFFF
`define JIF_IR_FLASH_CTRL 16'h0082
`define JIF_IR_FLASH_DATA 16'h0083
`define JIF_IR_FLASH_ADDR 16'h0084
`define JIF_IR_CAPTURE 16'h0001

// Indirect command / answer layout
`define JIF_IND_W 20
`define JIF_IND_OP_HI 19
`define JIF_IND_OP_LO 18
`define JIF_IND_VAL_W 18
`define JIF_OP_READ 2'b10
`define JIF_OP_WRITE 2'b11

// Control register fields and reset
`define JIF_CTRL_RESET 8'h00
`define JIF_CTRL_SCRATCH 7
`define JIF_WMODE_STORE 3'b000
`define JIF_WMODE_PROG 3'b001
`define JIF_WMODE_ERASE 3'b010
`define JIF_RMODE_STORE 4'b0000
`define JIF_RMODE_BLOCK 4'b0001
`define JIF_RMODE_SINGLE 4'b0010
`define JIF_ERASE_KEY 8'hA5

// Data port fields and reset
`define JIF_DATA_RESET 10'h000
`define JIF_DATA_FAIL 1
`define JIF_DATA_BUSY 0
`define JIF_ADDR_RESET 16'h0000

// Commands to the flash array
`define JIF_FL_READ 2'b00
`define JIF_FL_PROG 2'b01
`define JIF_FL_ERASE_PAGE 2'b10
`define JIF_FL_ERASE_ALL 2'b11

`endif

// ==== rtl/jif_flash_prog.v ====
`timescale 1ns/1ps
`include "jif_regs.vh"

module jif_flash_prog #(
  parameter [31:0] ID_VALUE = 32'h0000_0001, // Arbitrary identity value
  parameter [15:0] LOCK_RD_ADDR = 16'hFFFE,
  parameter [15:0] LOCK_WE_ADDR = 16'hFFFF
) (
  input wire ref_clk, // 200 MHz core clock
  input wire rst, // Synchronous reset, active high
  input wire tck, // Test clock from host
  input wire tms, // Test mode select
  input wire tdi, // Test data in
  output reg tdo_reg, // Test data out
  output reg tdo_oe_n_reg, // Low while tdo is driven
  output reg fl_req_reg, // Flash request, held until done
  output reg [1:0] fl_cmd_reg, // Flash command code
  output reg [15:0] fl_addr_reg, // Flash byte address
  output reg [7:0] fl_wdata_reg, // Byte to program
  output reg fl_scratch_reg, // Scratchpad sector selected
  input wire fl_done, // Flash operation finished (pulse)
  input wire fl_fail, // Finished operation failed
  input wire [7:0] fl_rdata // Read byte, valid with fl_done
);

  // Tap controller states
  localparam [3:0] ST_TLR = 4'h0;
  localparam [3:0] ST_RTI = 4'h1;
  localparam [3:0] ST_SEL_DR = 4'h2;
  localparam [3:0] ST_CAP_DR = 4'h3;
  localparam [3:0] ST_SH_DR = 4'h4;
  localparam [3:0] ST_EX1_DR = 4'h5;
  localparam [3:0] ST_PA_DR = 4'h6;
  localparam [3:0] ST_EX2_DR = 4'h7;
  localparam [3:0] ST_UP_DR = 4'h8;
  localparam [3:0] ST_SEL_IR = 4'h9;
  localparam [3:0] ST_CAP_IR = 4'hA;
  localparam [3:0] ST_SH_IR = 4'hB;
  localparam [3:0] ST_EX1_IR = 4'hC;
  localparam [3:0] ST_PA_IR = 4'hD;
  localparam [3:0] ST_EX2_IR = 4'hE;
  localparam [3:0] ST_UP_IR = 4'hF;

  // Synchronisers and edge detection
  reg tck_s1_reg, tck_s2_reg, tck_d_reg;
  reg tms_s1_reg, tms_s2_reg;
  reg tdi_s1_reg, tdi_s2_reg;
  wire tck_rise = tck_s2_reg & ~tck_d_reg;
  wire tck_fall = ~tck_s2_reg & tck_d_reg;

  // Tap state and shift paths
  reg [3:0] tap_reg, tap_next;
  reg [15:0] ir_reg, ir_sh_reg;
  reg [19:0] ind_sh_reg;
  reg [31:0] id_sh_reg;
  reg byp_reg;
  reg cap_busy_reg;

  // Indirect engine and register file
  reg ind_busy_reg;
  reg exec_reg;
  reg exec_wr_reg;
  reg [1:0] exec_tgt_reg;
  reg [17:0] exec_val_reg;
  reg [17:0] rd_val_reg;
  reg [7:0] ctrl_reg;
  reg [7:0] data_byte_reg;
  reg fail_reg;
  reg fl_busy_reg;
  reg unread_reg;
  reg [15:0] addr_reg;

  localparam [1:0] TGT_CTRL = 2'd0;
  localparam [1:0] TGT_DATA = 2'd1;
  localparam [1:0] TGT_ADDR = 2'd2;
  localparam [1:0] TGT_NONE = 2'd3;

  reg [1:0] ir_tgt;
  wire [2:0] write_mode_field = ctrl_reg[6:4];
  wire [3:0] read_mode_field = ctrl_reg[3:0];
  wire [9:0] flash_data_port = {data_byte_reg, fail_reg, fl_busy_reg};
  wire is_lock = (addr_reg == LOCK_RD_ADDR) | (addr_reg == LOCK_WE_ADDR);

  // Map instruction to indirect target
  always @*
  begin
    case (ir_reg)
      `JIF_IR_FLASH_CTRL: ir_tgt = TGT_CTRL;
      `JIF_IR_FLASH_DATA: ir_tgt = TGT_DATA;
      `JIF_IR_FLASH_ADDR: ir_tgt = TGT_ADDR;
      default: ir_tgt = TGT_NONE;
    endcase
  end

  // Two flops on each test pin (tck, tms, tdi) before use; third tck flop for edges
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      tck_s1_reg <= 1'b0;
      tck_s2_reg <= 1'b0;
      tck_d_reg <= 1'b0;
      tms_s1_reg <= 1'b1;
      tms_s2_reg <= 1'b1;
      tdi_s1_reg <= 1'b0;
      tdi_s2_reg <= 1'b0;
    end
    else
    begin
      tck_s1_reg <= tck;
      tck_s2_reg <= tck_s1_reg;
      tck_d_reg <= tck_s2_reg;
      tms_s1_reg <= tms;
      tms_s2_reg <= tms_s1_reg;
      tdi_s1_reg <= tdi;
      tdi_s2_reg <= tdi_s1_reg;
    end
  end

  // Standard tap state transitions
  always @*
  begin
    case (tap_reg)
      ST_TLR: tap_next = tms_s2_reg ? ST_TLR : ST_RTI;
      ST_RTI: tap_next = tms_s2_reg ? ST_SEL_DR : ST_RTI;
      ST_SEL_DR: tap_next = tms_s2_reg ? ST_SEL_IR : ST_CAP_DR;
      ST_CAP_DR: tap_next = tms_s2_reg ? ST_EX1_DR : ST_SH_DR;
      ST_SH_DR: tap_next = tms_s2_reg ? ST_EX1_DR : ST_SH_DR;
      ST_EX1_DR: tap_next = tms_s2_reg ? ST_UP_DR : ST_PA_DR;
      ST_PA_DR: tap_next = tms_s2_reg ? ST_EX2_DR : ST_PA_DR;
      ST_EX2_DR: tap_next = tms_s2_reg ? ST_UP_DR : ST_SH_DR;
      ST_UP_DR: tap_next = tms_s2_reg ? ST_SEL_DR : ST_RTI;
      ST_SEL_IR: tap_next = tms_s2_reg ? ST_TLR : ST_CAP_IR;
      ST_CAP_IR: tap_next = tms_s2_reg ? ST_EX1_IR : ST_SH_IR;
      ST_SH_IR: tap_next = tms_s2_reg ? ST_EX1_IR : ST_SH_IR;
      ST_EX1_IR: tap_next = tms_s2_reg ? ST_UP_IR : ST_PA_IR;
      ST_PA_IR: tap_next = tms_s2_reg ? ST_EX2_IR : ST_PA_IR;
      ST_EX2_IR: tap_next = tms_s2_reg ? ST_UP_IR : ST_SH_IR;
      ST_UP_IR: tap_next = tms_s2_reg ? ST_SEL_DR : ST_RTI;
      default: tap_next = ST_TLR;
    endcase
  end

  // Tap actions on each rising test clock edge
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      tap_reg <= ST_TLR;
      ir_reg <= `JIF_IR_IDCODE;
      ir_sh_reg <= 16'h0000;
      ind_sh_reg <= 20'h0_0000;
      id_sh_reg <= 32'h0000_0000;
      byp_reg <= 1'b0;
      cap_busy_reg <= 1'b0;
    end
    else if (tck_rise)
    begin
      tap_reg <= tap_next;
      case (tap_reg)
        ST_TLR: ir_reg <= `JIF_IR_IDCODE;
        ST_CAP_IR: ir_sh_reg <= `JIF_IR_CAPTURE;
        ST_SH_IR: ir_sh_reg <= {tdi_s2_reg, ir_sh_reg[15:1]};
        ST_UP_IR: ir_reg <= ir_sh_reg;
        ST_CAP_DR:
        begin
          // Answer layout; busy first out so one shift polls it
          ind_sh_reg <= {1'b0, rd_val_reg, ind_busy_reg};
          cap_busy_reg <= ind_busy_reg;
          id_sh_reg <= ID_VALUE;
          byp_reg <= 1'b0;
        end
        ST_SH_DR:
        begin
          // Host data enters at the top, so short shifts left-justify
          ind_sh_reg <= {tdi_s2_reg, ind_sh_reg[19:1]};
          id_sh_reg <= {tdi_s2_reg, id_sh_reg[31:1]};
          byp_reg <= tdi_s2_reg;
        end
        default: ;
      endcase
    end
  end

  // Tdo changes on the falling test clock edge
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      tdo_reg <= 1'b0;
      tdo_oe_n_reg <= 1'b1;
    end
    else if (tck_fall)
    begin
      tdo_oe_n_reg <= ~((tap_reg == ST_SH_DR) | (tap_reg == ST_SH_IR));
      if (tap_reg == ST_SH_IR)
        tdo_reg <= ir_sh_reg[0];
      else if (ir_tgt != TGT_NONE)
        tdo_reg <= ind_sh_reg[0];
      else if (ir_reg == `JIF_IR_IDCODE)
        tdo_reg <= id_sh_reg[0];
      else
        tdo_reg <= byp_reg;
    end
  end

  // Update-DR with a read or write opcode may launch a command.
  // Poll opcodes (top bit zero) never update anything.
  wire upd_dr = tck_rise & (tap_reg == ST_UP_DR) & (ir_tgt != TGT_NONE);
  wire cmd_ok = ind_sh_reg[`JIF_IND_OP_HI];
  // Busy seen at capture or still busy now: command dropped
  wire cmd_start = upd_dr & cmd_ok & ~cap_busy_reg
                   & ~ind_busy_reg;

  // Data-port decisions for the executing command
  wire ex_data = exec_reg & (exec_tgt_reg == TGT_DATA);
  wire [7:0] ex_byte = exec_val_reg[17:10];
  wire wr_prog = ex_data & exec_wr_reg & ~fl_busy_reg
                 & (write_mode_field == `JIF_WMODE_PROG);
  wire wr_erase = ex_data & exec_wr_reg & ~fl_busy_reg
                  & (write_mode_field == `JIF_WMODE_ERASE)
                  & (ex_byte == `JIF_ERASE_KEY);
  wire rd_block = (read_mode_field == `JIF_RMODE_BLOCK);
  wire rd_single = (read_mode_field == `JIF_RMODE_SINGLE)
                   & ~unread_reg;
  // Other modes fall through and start nothing
  wire rd_go = ex_data & ~exec_wr_reg & ~fl_busy_reg
               & (rd_block | rd_single);
  wire fl_fin = fl_req_reg & fl_done;

  // Indirect engine, register file and flash sequencer
  always @(posedge ref_clk)
  begin
    if (rst)
    begin
      ind_busy_reg <= 1'b0;
      exec_reg <= 1'b0;
      exec_wr_reg <= 1'b0;
      exec_tgt_reg <= TGT_CTRL;
      exec_val_reg <= 18'h0_0000;
      rd_val_reg <= 18'h0_0000;
      ctrl_reg <= `JIF_CTRL_RESET;
      data_byte_reg <= 8'h00;
      fail_reg <= 1'b0;
      fl_busy_reg <= 1'b0;
      unread_reg <= 1'b0;
      addr_reg <= `JIF_ADDR_RESET;
      fl_req_reg <= 1'b0;
      fl_cmd_reg <= `JIF_FL_READ;
      fl_addr_reg <= 16'h0000;
      fl_wdata_reg <= 8'h00;
      fl_scratch_reg <= 1'b0;
    end
    else
    begin
      // Launch: busy rises in the same cycle the command is taken
      if (cmd_start)
      begin
        ind_busy_reg <= 1'b1;
        exec_reg <= 1'b1;
        exec_wr_reg <= ind_sh_reg[`JIF_IND_OP_LO];
        exec_tgt_reg <= ir_tgt;
        exec_val_reg <= ind_sh_reg[17:0];
      end
      // Execute one cycle later, then drop busy
      if (exec_reg)
      begin
        exec_reg <= 1'b0;
        ind_busy_reg <= 1'b0;
        if (exec_wr_reg)
        begin
          // Narrow targets take the top bits of the value
          case (exec_tgt_reg)
            TGT_CTRL: ctrl_reg <= exec_val_reg[17:10];
            TGT_ADDR: addr_reg <= exec_val_reg[17:2];
            TGT_DATA: data_byte_reg <= ex_byte;
            default: ;
          endcase
        end
        else
        begin
          // Right-justified answer above the busy bit
          case (exec_tgt_reg)
            TGT_CTRL: rd_val_reg <= {10'h000, ctrl_reg};
            TGT_ADDR: rd_val_reg <= {2'b00, addr_reg};
            TGT_DATA: rd_val_reg <= {8'h00, flash_data_port};
            default: rd_val_reg <= 18'h0_0000;
          endcase
          if (exec_tgt_reg == TGT_DATA)
            unread_reg <= 1'b0;
        end
      end
      // Start a flash operation from the data port
      if (wr_prog | wr_erase | rd_go)
      begin
        fl_req_reg <= 1'b1;
        fl_busy_reg <= 1'b1;
        fl_addr_reg <= addr_reg;
        fl_wdata_reg <= ex_byte;
        fl_scratch_reg <= ctrl_reg[`JIF_CTRL_SCRATCH];
        if (wr_prog)
          fl_cmd_reg <= `JIF_FL_PROG;
        else if (wr_erase)
          fl_cmd_reg <= is_lock ? `JIF_FL_ERASE_ALL
                                : `JIF_FL_ERASE_PAGE;
        else
          fl_cmd_reg <= `JIF_FL_READ;
      end
      // Completion; placed last so a fresh result beats a read clear
      if (fl_fin)
      begin
        fl_req_reg <= 1'b0;
        fl_busy_reg <= 1'b0;
        fail_reg <= fl_fail;
        if (fl_cmd_reg == `JIF_FL_READ)
        begin
          data_byte_reg <= fl_rdata;
          unread_reg <= 1'b1;
        end
        // Erase leaves the pointer alone; read and program advance it
        if ((fl_cmd_reg == `JIF_FL_READ) | (fl_cmd_reg == `JIF_FL_PROG))
          addr_reg <= addr_reg + 16'h0001;
      end
    end
  end

endmodule // jif_flash_prog

// ==== sim/jif_flash_model.sv ====
`timescale 1ns/1ps
`include "jif_regs.vh"
// Flash array stand-in: one request at a time, answered lat+1 cycles after the request rises
module jif_flash_model (
  input wire ref_clk, // Core clock
  input wire rst, // Synchronous reset
  input wire fl_req_reg, // Request level
  input wire [1:0] fl_cmd_reg, // Command code
  input wire [15:0] fl_addr_reg, // Byte address
  input wire [7:0] fl_wdata_reg, // Byte to program
  input wire fl_scratch_reg, // Scratchpad chosen
  input wire [9:0] lat, // Done comes lat+1 cycles after the request rises
  input wire fail_set, // Next answer fails
  output reg fl_done = 1'b0, // Completion pulse
  output reg fl_fail = 1'b0, // Failure with done
  output reg [7:0] fl_rdata = 8'h00, // Read byte with done
  output reg [15:0] n_req = 16'h0000, // Requests served
  output reg [1:0] last_cmd = 2'b00 // Last command served
);
  reg [7:0] mem [0:131071];
  reg [9:0] cnt = 10'h000;
  // Answer lines toggle outside done so a stale value is never seen
  always @(posedge ref_clk)
  begin
    fl_done <= 1'b0;
    fl_fail <= ~fl_fail;
    fl_rdata <= ~fl_rdata;
    if (rst)
    begin
      cnt <= 10'h000;
      n_req <= 16'h0000;
    end
    else if (fl_req_reg && !fl_done)
    begin
      cnt <= cnt + 10'h001;
      if (cnt == lat)
      begin
        cnt <= 10'h000;
        fl_done <= 1'b1;
        fl_fail <= fail_set;
        fl_rdata <= mem[{fl_scratch_reg, fl_addr_reg}];
        n_req <= n_req + 16'h0001;
        last_cmd <= fl_cmd_reg;
        if (fl_cmd_reg == `JIF_FL_PROG)
          mem[{fl_scratch_reg, fl_addr_reg}] <= fl_wdata_reg;
      end
    end
  end
endmodule // jif_flash_model

// ==== sim/jif_flash_prog_properties.sv ====
`timescale 1ns/1ps
`include "jif_regs.vh"
// Port-level checks of the flash request and test data out timing
module jif_flash_prog_props #(
  parameter [15:0] LOCK_RD_ADDR = 16'hfffe,
  parameter [15:0] LOCK_WE_ADDR = 16'hffff
) (
  input wire ref_clk, // Core clock
  input wire rst, // Synchronous reset
  input wire tck, // Test clock
  input wire tdo_reg, // Test data out
  input wire tdo_oe_n_reg, // Data out enable
  input wire fl_req_reg, // Flash request
  input wire [1:0] fl_cmd_reg, // Flash command
  input wire [15:0] fl_addr_reg, // Flash address
  input wire [7:0] fl_wdata_reg, // Write byte
  input wire fl_scratch_reg, // Scratchpad select
  input wire fl_done // Flash done
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  // Lock byte addresses turn a page erase into a full erase
  wire lock_hit = (fl_addr_reg == LOCK_RD_ADDR) ||
    (fl_addr_reg == LOCK_WE_ADDR);
  AST_RST_IDLE: assert property ($fell(rst) |-> !fl_req_reg && tdo_oe_n_reg)
    else $error("outputs not idle after reset");
  AST_REQ_HOLD: assert property (fl_req_reg && !fl_done |=> fl_req_reg && $stable(fl_cmd_reg) && $stable(fl_addr_reg) && $stable(fl_wdata_reg))
    else $error("request changed before done");
  AST_REQ_DROP: assert property (fl_req_reg && fl_done |=> !fl_req_reg)
    else $error("request kept after done");
  AST_SCR_HOLD: assert property (fl_req_reg ##1 fl_req_reg |-> $stable(fl_scratch_reg))
    else $error("sector select moved in a request");
  AST_ERASE_KEY: assert property ($rose(fl_req_reg) && fl_cmd_reg[1] |-> fl_wdata_reg == `JIF_ERASE_KEY)
    else $error("erase without key byte");
  AST_ERASE_ALL: assert property ($rose(fl_req_reg) && fl_cmd_reg == `JIF_FL_ERASE_ALL |-> lock_hit)
    else $error("full erase off a lock byte");
  AST_ERASE_PAGE: assert property ($rose(fl_req_reg) && fl_cmd_reg == `JIF_FL_ERASE_PAGE |-> !lock_hit)
    else $error("page erase on a lock byte");
  AST_TDO_EDGE: assert property ($changed(tdo_reg) |-> !tck)
    else $error("data out moved while test clock high");
  AST_OE_EDGE: assert property ($changed(tdo_oe_n_reg) |-> !tck)
    else $error("enable moved while test clock high");
endmodule // jif_flash_prog_props
bind jif_flash_prog jif_flash_prog_props #(.LOCK_RD_ADDR(LOCK_RD_ADDR),
  .LOCK_WE_ADDR(LOCK_WE_ADDR)) u_props (.ref_clk(ref_clk), .rst(rst),
  .tck(tck), .tdo_reg(tdo_reg), .tdo_oe_n_reg(tdo_oe_n_reg),
  .fl_req_reg(fl_req_reg), .fl_cmd_reg(fl_cmd_reg),
  .fl_addr_reg(fl_addr_reg), .fl_wdata_reg(fl_wdata_reg),
  .fl_scratch_reg(fl_scratch_reg), .fl_done(fl_done));

// ==== sim/tb_jtag_indirect_flash_programmer.sv ====
`timescale 1ns/1ps
`include "jif_regs.vh"
module tb_jtag_indirect_flash_programmer;
  localparam [31:0] ID = 32'h1234_5670; // Arbitrary identity value
  reg ref_clk = 1'b0;
  reg rst = 1'b1;
  reg tck = 1'b0;
  reg tms = 1'b1;
  reg tdi = 1'b0;
  reg [9:0] lat = 10'h003;
  reg fail_set = 1'b0;
  wire tdo_reg, tdo_oe_n_reg, fl_req_reg, fl_scratch_reg;
  wire fl_done, fl_fail;
  wire [1:0] fl_cmd_reg, last_cmd;
  wire [15:0] fl_addr_reg, n_req;
  wire [7:0] fl_wdata_reg, fl_rdata;
  integer n_mismatch = 0;
  integer num_checks = 0;
  integer cyc = 0;
  integer k;
  reg [15:0] cur_ir = 16'h0004;
  reg [15:0] base, n0;
  reg [31:0] r;
  reg [7:0] b [0:3];
  reg [7:0] x;
  reg q;
  reg qe;
  jif_flash_prog #(.ID_VALUE(ID)) u_dut (.ref_clk(ref_clk), .rst(rst),
    .tck(tck), .tms(tms), .tdi(tdi), .tdo_reg(tdo_reg),
    .tdo_oe_n_reg(tdo_oe_n_reg), .fl_req_reg(fl_req_reg),
    .fl_cmd_reg(fl_cmd_reg), .fl_addr_reg(fl_addr_reg),
    .fl_wdata_reg(fl_wdata_reg), .fl_scratch_reg(fl_scratch_reg),
    .fl_done(fl_done), .fl_fail(fl_fail), .fl_rdata(fl_rdata));
  jif_flash_model u_flash (.ref_clk(ref_clk), .rst(rst),
    .fl_req_reg(fl_req_reg), .fl_cmd_reg(fl_cmd_reg),
    .fl_addr_reg(fl_addr_reg), .fl_wdata_reg(fl_wdata_reg),
    .fl_scratch_reg(fl_scratch_reg), .lat(lat), .fail_set(fail_set),
    .fl_done(fl_done), .fl_fail(fl_fail), .fl_rdata(fl_rdata),
    .n_req(n_req), .last_cmd(last_cmd));
  // Core clock; the test clock only runs inside tick calls
  always #2.5 ref_clk = ~ref_clk;
  // Cycle ceiling against a hung handshake
  always @(posedge ref_clk)
  begin
    cyc = cyc + 1;
    if (cyc == 60000)
    begin
      n_mismatch = n_mismatch + 1;
      give_verdict;
    end
  end
  // Expected indirect answer: value right above a clear busy bit
  function [31:0] ans(input [17:0] v);
    ans = {13'h0000, v, 1'b0};
  endfunction
  // Controls whose write and read modes start nothing
  function [7:0] md(input integer i);
    md = (i == 0) ? 8'h00 : (i == 1) ? 8'h77 : 8'h3f;
  endfunction
  task give_verdict;
  begin
    $display("checks %0d mismatches %0d", num_checks, n_mismatch);
    if (n_mismatch == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  end
  endtask
  task chk(input string nm, input [31:0] e, input [31:0] g);
  begin
    num_checks = num_checks + 1;
    if (g !== e)
    begin
      n_mismatch = n_mismatch + 1;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  end
  endtask
  // One test clock period, 80 ns; data out sampled before the rise
  task tick(input m, input d);
  begin
    tms = m;
    tdi = d;
    repeat (8) @(posedge ref_clk);
    #1 q = tdo_reg;
    qe = tdo_oe_n_reg;
    tck = 1'b1;
    repeat (8) @(posedge ref_clk);
    #1 tck = 1'b0;
  end
  endtask
  // From idle through one IR or DR scan, LSB first, back to idle
  task scan(input ir, input integer n, input [31:0] v);
    integer i;
  begin
    r = 0;
    tick(1, 0);
    if (ir) tick(1, 0);
    tick(0, 0);
    tick(0, 0);
    for (i = 0; i < n; i = i + 1)
    begin
      tick(i == n - 1, v[i]);
      r[i] = q;
    end
    chk("tdo enable", 0, qe);
    tick(1, 0);
    chk("tdo release", 1, qe);
    tick(0, 0);
  end
  endtask
  // Short command; the instruction is only rescanned when it changes
  task cmd(input [15:0] ir, input integer n, input [31:0] v);
  begin
    if (ir !== cur_ir) scan(1, 16, ir);
    cur_ir = ir;
    scan(0, n, v);
  end
  endtask
  task rd(input [15:0] ir, input integer n);
  begin
    cmd(ir, 2, 32'h0000_0002);
    scan(0, n, 32'h0000_0000);
  end
  endtask
  initial
  begin
    void'($urandom(63));
    repeat (16) @(posedge ref_clk);
    #1 rst = 1'b0;
    tick(0, 0);
    scan(0, 32, 32'h0000_0000);
    chk("idcode", ID, r);
    rd(`JIF_IR_FLASH_CTRL, 9);
    chk("ctrl reset", ans(0), r);
    cmd(`JIF_IR_FLASH_CTRL, 10, {2'b11, 8'h11});
    rd(`JIF_IR_FLASH_CTRL, 9);
    chk("ctrl", ans(8'h11), r);
    base = $urandom & 16'h0ff0;
    cmd(`JIF_IR_FLASH_ADDR, 18, {2'b11, base});
    for (k = 0; k < 4; k = k + 1)
    begin
      b[k] = $urandom;
      cmd(`JIF_IR_FLASH_DATA, 10, {2'b11, b[k]});
    end
    chk("prog count", 4, n_req);
    chk("prog cmd", `JIF_FL_PROG, last_cmd);
    rd(`JIF_IR_FLASH_ADDR, 17);
    chk("addr", ans(base + 16'h0004), r);
    cmd(`JIF_IR_FLASH_CTRL, 10, {2'b11, 8'h01});
    cmd(`JIF_IR_FLASH_ADDR, 18, {2'b11, base});
    rd(`JIF_IR_FLASH_DATA, 11);
    for (k = 0; k < 4; k = k + 1)
    begin
      rd(`JIF_IR_FLASH_DATA, 11);
      chk("block byte", ans({b[k], 2'b00}), r);
    end
    rd(`JIF_IR_FLASH_ADDR, 17);
    chk("addr", ans(base + 16'h0005), r);
    // Single mode: last block byte still uncollected, so one read is spent
    cmd(`JIF_IR_FLASH_CTRL, 10, {2'b11, 8'h02});
    cmd(`JIF_IR_FLASH_ADDR, 18, {2'b11, base});
    n0 = n_req;
    for (k = 0; k < 3; k = k + 1)
      rd(`JIF_IR_FLASH_DATA, 11);
    chk("single byte", ans({b[0], 2'b00}), r);
    chk("single count", n0 + 1, n_req);
    n0 = n_req;
    for (k = 0; k < 3; k = k + 1)
    begin
      x = $urandom;
      cmd(`JIF_IR_FLASH_CTRL, 10, {2'b11, md(k)});
      cmd(`JIF_IR_FLASH_DATA, 10, {2'b11, x});
      rd(`JIF_IR_FLASH_DATA, 11);
      chk("stored", ans({x, 2'b00}), r);
    end
    chk("no op", n0, n_req);
    cmd(`JIF_IR_FLASH_CTRL, 10, {2'b11, 8'h20});
    cmd(`JIF_IR_FLASH_ADDR, 18, {2'b11, base});
    cmd(`JIF_IR_FLASH_DATA, 10, {2'b11, 8'h5a});
    chk("bad key", n0, n_req);
    cmd(`JIF_IR_FLASH_DATA, 10, {2'b11, `JIF_ERASE_KEY});
    chk("erase", `JIF_FL_ERASE_PAGE, last_cmd);
    rd(`JIF_IR_FLASH_ADDR, 17);
    chk("addr", ans(base), r);
    cmd(`JIF_IR_FLASH_ADDR, 18, {2'b11, 16'hffff});
    cmd(`JIF_IR_FLASH_DATA, 10, {2'b11, `JIF_ERASE_KEY});
    chk("erase all", `JIF_FL_ERASE_ALL, last_cmd);
    fail_set = 1'b1;
    cmd(`JIF_IR_FLASH_CTRL, 10, {2'b11, 8'h10});
    cmd(`JIF_IR_FLASH_ADDR, 18, {2'b11, base});
    for (k = 0; k < 2; k = k + 1)
    begin
      cmd(`JIF_IR_FLASH_DATA, 10, {2'b11, b[k]});
      rd(`JIF_IR_FLASH_DATA, 11);
      chk("fail", 1 - k, r[2]);
      fail_set = 1'b0;
    end
    rd(`JIF_IR_FLASH_ADDR, 17);
    chk("addr", ans(base + 16'h0002), r);
    lat = 10'h3e8;
    n0 = n_req;
    cmd(`JIF_IR_FLASH_DATA, 10, {2'b11, b[2]});
    rd(`JIF_IR_FLASH_DATA, 11);
    chk("flash busy", 1, r[1]);
    cmd(`JIF_IR_FLASH_DATA, 10, {2'b11, b[3]});
    repeat (1200) @(posedge ref_clk);
    chk("busy refuse", n0 + 1, n_req);
    lat = 10'h003;
    x = $urandom;
    cmd(`JIF_IR_FLASH_CTRL, 10, {2'b11, 8'h90});
    cmd(`JIF_IR_FLASH_ADDR, 18, {2'b11, 16'h0010});
    cmd(`JIF_IR_FLASH_DATA, 10, {2'b11, x});
    chk("scratch", x, u_flash.mem[17'h1_0010]);
    give_verdict;
  end
endmodule // tb_jtag_indirect_flash_programmer
